// ### hw/scmc_map.svh
`ifndef SCMC_MAP_SVH
`define SCMC_MAP_SVH

// register indexes, byte address is four times the index
`define SCMC_IDX_MODE0    24'h0f0110
`define SCMC_IDX_MODE1    24'h0f0112
`define SCMC_IDX_CTRL     24'h0f0114
`define SCMC_IDX_STAT     24'h0f0115
`define SCMC_IDX_IRQ_STAT 24'h0f0116
`define SCMC_IDX_IRQ_EN   24'h0f0117
`define SCMC_IDX_IRQ_CLR  24'h0f0118
`define SCMC_IDX_DATA0    24'h0fff10
`define SCMC_IDX_DATA1    24'h0fff12

// mode register layout
`define SCMC_MODE_RESET   16'h0020
`define SCMC_MODE_WMASK0  16'hc003
`define SCMC_MODE_WMASK1  16'hc143
`define SCMC_MODE_RUNMASK 16'h0001

// control register fields
`define SCMC_CTRL_UNIT_EN 0
`define SCMC_CTRL_START   1
`define SCMC_CTRL_STOP    3

// data register fields
`define SCMC_DATA_DIV_LSB 9
`define SCMC_DATA_RESET   16'h0000

// bits per transfer
`define SCMC_FRAME_BITS   4'h8

`endif

// ### hw/scmc_pkg.sv
package scmc_pkg;

    typedef struct packed {
        logic       op_clk_sel;
        logic       xfer_clk_sel;
        logic [4:0] rsv_hi;
        logic       start_trig_sel;
        logic       rsv_mid;
        logic       rx_inv_sel;
        logic       one_bit;
        logic [2:0] rsv_lo;
        logic       protocol_mode_sel;
        logic       interrupt_source_sel;
    } scmc_mode_type;

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_ARMED,
        ST_SHIFT
    } scmc_state_type;

endpackage

// ### hw/scmc_top.sv
`timescale 1ns/10ps
`include "scmc_map.svh"
// Behaviour
// - mode register written only as 16 bits
// - mode registers reset to 0020h
// - operation clock picks shared clock a or b
// - operation clock divided by data upper bits plus one
// - transfer clock from divider or serial pin
// - transfer clock steps shift and control logic
// - start by software or receive pin edge
// - transfer waits for start bit then trigger
// - channel 0 lacks trigger and invert bits
// - invert off: falling start edge, data kept
// - invert on: rising start edge, data inverted in uart mode only
// - protocol bit selects clocked serial or uart
// - buffer empty interrupt on shift register load
// - unit clock off holds mode, data, buffer, receive data and sequence at defaults, not serial data out; ignores mode, data and start writes
module scmc_top (
    // clock, reset, enable
    input  wire logic        clk,
    input  wire logic        resetn,
    input  wire logic        ce,
    // apb slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [25:0] paddr,
    input  wire logic [31:0] pwdata,
    input  wire logic [3:0]  pstrb,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // shared prescaled clock ticks
    input  wire logic        shared_clock_a,
    input  wire logic        shared_clock_b,
    // serial pins
    input  wire logic [1:0]  serial_clock_pin,
    input  wire logic [1:0]  uart_receive_pin,
    output logic      [1:0]  serial_data_out,
    // interrupt
    output logic             irq
);

    logic                  rst_s1_reg;
    logic                  rst_s2_reg;
    logic                  rst_n;
    logic                  unit_en_reg;
    logic [15:0]           mode_reg [2];
    logic [15:0]           data_reg [2];
    logic [8:0]            rx_reg   [2];
    logic [1:0]            en_reg;
    logic [1:0]            buf_full_reg;
    logic [1:0]            busy;
    logic [1:0]            evt;
    logic [1:0]            irq_stat_reg;
    logic [1:0]            irq_en_reg;
    logic [31:0]           prdata_reg;
    logic [31:0]           rdata_next;
    logic                  wr;
    logic                  full16;
    logic                  hit_mode0;
    logic                  hit_mode1;
    logic                  hit_ctrl;
    logic                  hit_stat;
    logic                  hit_istat;
    logic                  hit_ien;
    logic                  hit_iclr;
    logic                  hit_data0;
    logic                  hit_data1;
    logic                  hit_any;
    logic [1:0]            start_wr;
    logic [1:0]            stop_wr;
    logic [1:0]            data_wr;

    // reset release
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            rst_s1_reg <= 1'b0;
            rst_s2_reg <= 1'b0;
        end else begin
            rst_s1_reg <= 1'b1;
            rst_s2_reg <= rst_s1_reg;
        end
    end
    assign rst_n = rst_s2_reg;

    // address decode
    assign hit_mode0 = paddr == {`SCMC_IDX_MODE0, 2'b00};
    assign hit_mode1 = paddr == {`SCMC_IDX_MODE1, 2'b00};
    assign hit_ctrl  = paddr == {`SCMC_IDX_CTRL, 2'b00};
    assign hit_stat  = paddr == {`SCMC_IDX_STAT, 2'b00};
    assign hit_istat = paddr == {`SCMC_IDX_IRQ_STAT, 2'b00};
    assign hit_ien   = paddr == {`SCMC_IDX_IRQ_EN, 2'b00};
    assign hit_iclr  = paddr == {`SCMC_IDX_IRQ_CLR, 2'b00};
    assign hit_data0 = paddr == {`SCMC_IDX_DATA0, 2'b00};
    assign hit_data1 = paddr == {`SCMC_IDX_DATA1, 2'b00};
    assign hit_any   = hit_mode0 | hit_mode1 | hit_ctrl | hit_stat | hit_istat
                     | hit_ien | hit_iclr | hit_data0 | hit_data1;

    assign wr      = psel & penable & pwrite & ce;
    assign full16  = &pstrb[1:0];
    assign pready  = 1'b1;
    assign pslverr = psel & penable & (~hit_any | (pwrite & ~full16));

    assign start_wr = (wr & hit_ctrl & unit_en_reg & pstrb[0])
                    ? pwdata[`SCMC_CTRL_START +: 2] : 2'b00;
    assign stop_wr  = (wr & hit_ctrl & unit_en_reg & pstrb[0])
                    ? pwdata[`SCMC_CTRL_STOP +: 2] : 2'b00;
    assign data_wr  = {wr & hit_data1 & full16 & unit_en_reg,
                       wr & hit_data0 & full16 & unit_en_reg};

    // unit clock supply enable
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            unit_en_reg <= 1'b0;
        end else if (ce && wr && hit_ctrl && pstrb[0]) begin
            unit_en_reg <= pwdata[`SCMC_CTRL_UNIT_EN];
        end
    end

    // interrupt status, enable and clear
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            irq_stat_reg <= 2'b00;
            irq_en_reg   <= 2'b00;
        end else if (ce) begin
            if (wr && hit_ien && pstrb[0]) begin
                irq_en_reg <= pwdata[1:0];
            end
            if (wr && hit_iclr && pstrb[0]) begin
                irq_stat_reg <= (irq_stat_reg & ~pwdata[1:0]) | evt;
            end else begin
                irq_stat_reg <= irq_stat_reg | evt;
            end
        end
    end
    assign irq = |(irq_stat_reg & irq_en_reg);

    // read data
    always_comb begin
        rdata_next = 32'h0000_0000;
        if (hit_mode0) begin
            rdata_next[15:0] = mode_reg[0];
        end else if (hit_mode1) begin
            rdata_next[15:0] = mode_reg[1];
        end else if (hit_ctrl) begin
            rdata_next[0] = unit_en_reg;
        end else if (hit_stat) begin
            rdata_next[5:0] = {busy, buf_full_reg, en_reg};
        end else if (hit_istat) begin
            rdata_next[1:0] = irq_stat_reg;
        end else if (hit_ien) begin
            rdata_next[1:0] = irq_en_reg;
        end else if (hit_data0) begin
            rdata_next[15:0] = {data_reg[0][15:9], rx_reg[0]};
        end else if (hit_data1) begin
            rdata_next[15:0] = {data_reg[1][15:9], rx_reg[1]};
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            prdata_reg <= 32'h0000_0000;
        end else if (ce && psel && !penable) begin
            prdata_reg <= rdata_next;
        end
    end
    assign prdata = prdata_reg;

    // per channel logic
    for (genvar ch = 0; ch < 2; ch++) begin : g_ch
        localparam logic [15:0] WMASK = (ch == 0) ? `SCMC_MODE_WMASK0
                                                  : `SCMC_MODE_WMASK1;
        scmc_pkg::scmc_mode_type mode;
        scmc_pkg::scmc_state_type state_reg;
        logic       mode_wr;
        logic [15:0] wmask;
        logic [6:0] div_cnt_reg;
        logic       div_tick;
        logic       op_tick;
        logic       sck_s1_reg;
        logic       sck_s2_reg;
        logic       sck_s3_reg;
        logic       rx_s1_reg;
        logic       rx_s2_reg;
        logic       rx_s3_reg;
        logic       sck_edge;
        logic       rx_edge;
        logic       rx_bit;
        logic       xfer_tick;
        logic       trigger;
        logic       load;
        logic       done;
        logic [8:0] shift_reg;
        logic [3:0] bit_cnt_reg;
        logic       empty_evt_reg;
        logic       done_evt_reg;
        logic       tx_reg;

        assign mode    = scmc_pkg::scmc_mode_type'(mode_reg[ch]);
        assign mode_wr = wr & full16 & unit_en_reg
                       & ((ch == 0) ? hit_mode0 : hit_mode1);
        assign wmask   = en_reg[ch] ? (WMASK & `SCMC_MODE_RUNMASK) : WMASK;

        // mode register
        always_ff @(posedge clk or negedge rst_n) begin
            if (!rst_n) begin
                mode_reg[ch] <= `SCMC_MODE_RESET;
            end else if (ce) begin
                if (!unit_en_reg) begin
                    mode_reg[ch] <= `SCMC_MODE_RESET;
                end else if (mode_wr) begin
                    mode_reg[ch] <= (mode_reg[ch] & ~wmask) | (pwdata[15:0] & wmask)
                                  | `SCMC_MODE_RESET;
                end
            end
        end

        // data register and buffer flag
        always_ff @(posedge clk or negedge rst_n) begin
            if (!rst_n) begin
                data_reg[ch]     <= `SCMC_DATA_RESET;
                buf_full_reg[ch] <= 1'b0;
            end else if (ce) begin
                if (!unit_en_reg) begin
                    data_reg[ch]     <= `SCMC_DATA_RESET;
                    buf_full_reg[ch] <= 1'b0;
                end else if (data_wr[ch]) begin
                    data_reg[ch]     <= pwdata[15:0];
                    buf_full_reg[ch] <= 1'b1;
                end else if (load) begin
                    buf_full_reg[ch] <= 1'b0;
                end
            end
        end

        // operation clock and divider
        assign op_tick  = mode.op_clk_sel ? shared_clock_b : shared_clock_a;
        assign div_tick = op_tick & (div_cnt_reg == data_reg[ch][15:9]);
        always_ff @(posedge clk or negedge rst_n) begin
            if (!rst_n) begin
                div_cnt_reg <= 7'h00;
            end else if (ce) begin
                if (state_reg != scmc_pkg::ST_SHIFT || div_tick) begin
                    div_cnt_reg <= 7'h00;
                end else if (op_tick) begin
                    div_cnt_reg <= div_cnt_reg + 7'h01;
                end
            end
        end

        // pin synchronisers
        always_ff @(posedge clk or negedge rst_n) begin
            if (!rst_n) begin
                sck_s1_reg <= 1'b0;
                sck_s2_reg <= 1'b0;
                sck_s3_reg <= 1'b0;
                rx_s1_reg  <= 1'b1;
                rx_s2_reg  <= 1'b1;
                rx_s3_reg  <= 1'b1;
            end else if (ce) begin
                sck_s1_reg <= serial_clock_pin[ch];
                sck_s2_reg <= sck_s1_reg;
                sck_s3_reg <= sck_s2_reg;
                rx_s1_reg  <= uart_receive_pin[ch];
                rx_s2_reg  <= rx_s1_reg;
                rx_s3_reg  <= rx_s2_reg;
            end
        end

        assign sck_edge  = sck_s2_reg & ~sck_s3_reg;
        assign xfer_tick = mode.xfer_clk_sel ? sck_edge : div_tick;
        assign rx_edge   = mode.rx_inv_sel ? (rx_s2_reg & ~rx_s3_reg)
                                           : (~rx_s2_reg & rx_s3_reg);
        assign rx_bit    = rx_s2_reg ^ (mode.protocol_mode_sel & mode.rx_inv_sel);
        assign trigger   = mode.start_trig_sel ? rx_edge : buf_full_reg[ch];
        assign load      = ce & unit_en_reg & (state_reg == scmc_pkg::ST_ARMED)
                         & trigger & ~stop_wr[ch];
        assign done      = (state_reg == scmc_pkg::ST_SHIFT) & xfer_tick
                         & (bit_cnt_reg == `SCMC_FRAME_BITS - 4'h1);

        // channel sequence
        always_ff @(posedge clk or negedge rst_n) begin
            if (!rst_n) begin
                state_reg  <= scmc_pkg::ST_IDLE;
                en_reg[ch] <= 1'b0;
            end else if (ce) begin
                if (!unit_en_reg || stop_wr[ch]) begin
                    state_reg  <= scmc_pkg::ST_IDLE;
                    en_reg[ch] <= 1'b0;
                end else begin
                    unique case (state_reg)
                        scmc_pkg::ST_IDLE: begin
                            if (start_wr[ch]) begin
                                state_reg  <= scmc_pkg::ST_ARMED;
                                en_reg[ch] <= 1'b1;
                            end
                        end
                        scmc_pkg::ST_ARMED: begin
                            if (load) begin
                                state_reg <= scmc_pkg::ST_SHIFT;
                            end
                        end
                        scmc_pkg::ST_SHIFT: begin
                            if (done) begin
                                state_reg <= scmc_pkg::ST_ARMED;
                            end
                        end
                    endcase
                end
            end
        end

        // shift register and bit count
        always_ff @(posedge clk or negedge rst_n) begin
            if (!rst_n) begin
                shift_reg    <= 9'h000;
                bit_cnt_reg  <= 4'h0;
                tx_reg       <= 1'b1;
                rx_reg[ch]   <= 9'h000;
            end else if (ce) begin
                if (!unit_en_reg) begin
                    rx_reg[ch] <= 9'h000;
                end else if (load) begin
                    shift_reg   <= buf_full_reg[ch] ? data_reg[ch][8:0] : 9'h000;
                    bit_cnt_reg <= 4'h0;
                end else if (state_reg == scmc_pkg::ST_SHIFT && xfer_tick) begin
                    tx_reg      <= shift_reg[7];
                    shift_reg   <= {1'b0, shift_reg[6:0], rx_bit};
                    bit_cnt_reg <= bit_cnt_reg + 4'h1;
                    if (done) begin
                        rx_reg[ch] <= {1'b0, shift_reg[6:0], rx_bit};
                    end
                end
            end
        end

        // interrupt events
        always_ff @(posedge clk or negedge rst_n) begin
            if (!rst_n) begin
                empty_evt_reg <= 1'b0;
                done_evt_reg  <= 1'b0;
            end else if (ce) begin
                empty_evt_reg <= load & buf_full_reg[ch] & mode.interrupt_source_sel;
                done_evt_reg  <= done & ~mode.interrupt_source_sel;
            end
        end

        assign evt[ch]             = empty_evt_reg | done_evt_reg;
        assign busy[ch]            = state_reg == scmc_pkg::ST_SHIFT;
        assign serial_data_out[ch] = tx_reg;
    end

endmodule

// ### sim/scmc_top_props.sv
`timescale 1ns/10ps
`include "scmc_map.svh"
module scmc_top_props (
    // clock and reset
    input logic        clk,
    input logic        resetn,
    input logic        ce,
    // apb
    input logic        psel,
    input logic        penable,
    input logic        pwrite,
    input logic [25:0] paddr,
    input logic [31:0] pwdata,
    input logic [3:0]  pstrb,
    input logic [31:0] prdata,
    input logic        pready,
    input logic        pslverr,
    // pins
    input logic [1:0]  serial_data_out,
    input logic        irq
);
    logic        acc;
    logic [23:0] idx;
    logic        md_hit;
    logic        known;

    assign acc = psel & penable & ce;
    assign idx = paddr[25:2];
    assign md_hit = idx == `SCMC_IDX_MODE0 || idx == `SCMC_IDX_MODE1
                 || idx == `SCMC_IDX_DATA0 || idx == `SCMC_IDX_DATA1;
    assign known = md_hit || (idx >= `SCMC_IDX_CTRL && idx <= `SCMC_IDX_IRQ_CLR);

    default clocking dc @(posedge clk);
    endclocking
    default disable iff (!resetn);

    chk_strobe_refused:
        assert property (acc && pwrite && md_hit && pstrb[1:0] != 2'b11 |-> pslverr)
        else $error("narrow mode write not refused");
    chk_upper_zero:
        assert property (acc && !pwrite && md_hit |-> prdata[31:16] == 16'h0000)
        else $error("upper half of 16 bit register not zero");
    chk_mode0_layout:
        assert property (acc && !pwrite && idx == `SCMC_IDX_MODE0
                         |-> (prdata & ~32'h0000c023) == 32'h0 && prdata[5])
        else $error("channel 0 mode reserved bits wrong");
    chk_mode1_layout:
        assert property (acc && !pwrite && idx == `SCMC_IDX_MODE1
                         |-> (prdata & ~32'h0000c163) == 32'h0 && prdata[5])
        else $error("channel 1 mode reserved bits wrong");
    chk_unmapped_err:
        assert property (acc && !pwrite && paddr[1:0] == 2'b00 && !known
                         |-> pslverr && prdata == 32'h0)
        else $error("unmapped read not refused");
    chk_err_access:
        assert property (pslverr |-> psel && penable)
        else $error("slave error outside access phase");
    chk_irq_masked:
        assert property (acc && pwrite && idx == `SCMC_IDX_IRQ_EN && pwdata[1:0] == 2'b00
                         |=> !irq[*2])
        else $error("interrupt high with all sources masked");
    chk_tx_idle:
        assert property ($rose(resetn) |-> serial_data_out == 2'b11 && !irq)
        else $error("outputs not idle at reset release");
endmodule

bind scmc_top scmc_top_props u_props (
    .clk             (clk),
    .resetn          (resetn),
    .ce              (ce),
    .psel            (psel),
    .penable         (penable),
    .pwrite          (pwrite),
    .paddr           (paddr),
    .pwdata          (pwdata),
    .pstrb           (pstrb),
    .prdata          (prdata),
    .pready          (pready),
    .pslverr         (pslverr),
    .serial_data_out (serial_data_out),
    .irq             (irq)
);

// ### sim/scmc_serial_peer.sv
`timescale 1ns/10ps
module scmc_serial_peer (
    // clock
    input  logic clk,
    // serial lines
    output logic sck,
    output logic rxd,
    input  logic txd
);
    initial begin
        sck = 1'b0;
        rxd = 1'b1;
    end

    // clocked frame, msb first, optional start edge; clock still outside
    task automatic frame(input logic [7:0] b, input logic inv, input logic strt,
                         input int half, output logic [7:0] got);
        int i;
        @(posedge clk);
        rxd <= ~inv;
        if (strt) begin
            repeat (half) @(posedge clk);
            rxd <= inv;
        end
        for (i = 7; i >= 0; i--) begin
            repeat (half) @(posedge clk);
            rxd <= b[i] ^ inv;
            repeat (half) @(posedge clk);
            sck <= 1'b1;
            repeat (half) @(posedge clk);
            sck <= 1'b0;
            // bit leaves on the synced rise, so look after it
            @(negedge clk);
            got[i] = txd;
        end
        repeat (half) @(posedge clk);
        rxd <= ~inv;
    endtask
endmodule

// ### sim/scmc_top_tb_top.sv
`timescale 1ns/10ps
`include "scmc_map.svh"
module scmc_top_tb_top;
    logic        clk = 1'b0;
    logic        resetn = 1'b0;
    logic        ce = 1'b1;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [25:0] paddr = 26'h0;
    logic [31:0] pwdata = 32'h0;
    logic [3:0]  pstrb = 4'h0;
    logic        ck_a = 1'b0;
    logic        ck_b = 1'b0;
    logic [1:0]  pc = 2'h0;
    int          nk;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        irq;
    logic [1:0]  sck;
    logic [1:0]  rxd;
    logic [1:0]  txd;
    logic [31:0] r;
    logic        e;
    logic [7:0]  got;
    logic [7:0]  b;
    logic [15:0] v;
    integer      seed = 32'hadf85e37;
    int          n_fail = 0;
    int          n_compared = 0;
    int          i;

    always #50 clk = ~clk;

    // tick a every 2 cycles, tick b every 4 cycles
    always @(posedge clk) begin
        pc   <= pc + 2'h1;
        ck_a <= ~ck_a;
        ck_b <= pc == 2'h3;
    end

    scmc_top dut (
        .clk              (clk),
        .resetn           (resetn),
        .ce               (ce),
        .psel             (psel),
        .penable          (penable),
        .pwrite           (pwrite),
        .paddr            (paddr),
        .pwdata           (pwdata),
        .pstrb            (pstrb),
        .prdata           (prdata),
        .pready           (pready),
        .pslverr          (pslverr),
        .shared_clock_a   (ck_a),
        .shared_clock_b   (ck_b),
        .serial_clock_pin (sck),
        .uart_receive_pin (rxd),
        .serial_data_out  (txd),
        .irq              (irq)
    );
    scmc_serial_peer p0 (.clk(clk), .sck(sck[0]), .rxd(rxd[0]), .txd(txd[0]));
    scmc_serial_peer p1 (.clk(clk), .sck(sck[1]), .rxd(rxd[1]), .txd(txd[1]));

    function automatic logic [31:0] exp_mode(input logic ch, input logic [15:0] w);
        return {16'h0, (w & (ch ? 16'hc143 : 16'hc003)) | 16'h0020};
    endfunction

    task chk(input string nm, input logic [31:0] ex, input logic [31:0] seen);
        n_compared++;
        if (seen !== ex) begin
            n_fail++;
            $display("Error %s expected %h seen %h", nm, ex, seen);
        end
    endtask

    task apb(input logic w, input logic [23:0] ix, input logic [31:0] d, input logic [3:0] s);
        int k;
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= {ix, 2'b00};
        pwdata <= d;
        pstrb <= s;
        @(posedge clk);
        penable <= 1'b1;
        k = 0;
        do begin
            @(posedge clk);
            k++;
        end while (pready !== 1'b1 && k < 100);
        if (k >= 100) begin
            n_fail++;
        end
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task wait_irq;
        int k;
        k = 0;
        while (irq !== 1'b1 && k < 300) begin
            @(posedge clk);
            k++;
        end
        nk = k;
    endtask

    task print_verdict;
        $display("compared %0d failed %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    initial begin
        repeat (30000) @(posedge clk);
        n_fail++;
        print_verdict;
    end

    initial begin
        repeat (20) @(posedge clk);
        resetn <= 1'b1;
        repeat (3) @(posedge clk);
        apb(1'b0, `SCMC_IDX_MODE0, 32'h0, 4'hf);
        chk("mode0 reset", 32'h0020, r);
        apb(1'b0, `SCMC_IDX_MODE1, 32'h0, 4'hf);
        chk("mode1 reset", 32'h0020, r);
        apb(1'b1, `SCMC_IDX_MODE0, 32'hc003, 4'hf);
        apb(1'b0, `SCMC_IDX_MODE0, 32'h0, 4'hf);
        chk("mode0 clock off", 32'h0020, r);
        apb(1'b1, `SCMC_IDX_CTRL, 32'h1, 4'hf);
        for (i = 0; i < 8; i++) begin
            v = (i == 0) ? 16'hffff : 16'($random(seed));
            apb(1'b1, i[0] ? `SCMC_IDX_MODE1 : `SCMC_IDX_MODE0, {16'h0, v}, 4'hf);
            apb(1'b0, i[0] ? `SCMC_IDX_MODE1 : `SCMC_IDX_MODE0, 32'h0, 4'hf);
            chk("mode layout", exp_mode(i[0], v), r);
        end
        apb(1'b1, `SCMC_IDX_MODE1, 32'h0, 4'h1);
        chk("narrow write err", 32'h1, 32'(e));
        apb(1'b0, `SCMC_IDX_MODE1, 32'h0, 4'hf);
        chk("mode1 kept", exp_mode(1'b1, v), r);
        apb(1'b0, 24'h0f0120, 32'h0, 4'hf);
        chk("unmapped err", 32'h1, 32'(e));
        // channel 0: clocked serial, pin clock, buffer empty event
        apb(1'b1, `SCMC_IDX_IRQ_EN, 32'h3, 4'hf);
        apb(1'b1, `SCMC_IDX_DATA0, {16'h0, 7'h02, 9'h0a5}, 4'hf);
        apb(1'b1, `SCMC_IDX_MODE0, 32'h4021, 4'hf);
        apb(1'b1, `SCMC_IDX_CTRL, 32'h3, 4'hf);
        wait_irq;
        chk("irq on load", 32'h1, 32'(irq));
        apb(1'b0, `SCMC_IDX_IRQ_STAT, 32'h0, 4'hf);
        chk("status on load", 32'h1, r);
        p0.frame(8'h3c, 1'b0, 1'b0, 4, got);
        chk("tx0 byte", 32'h00a5, 32'(got));
        apb(1'b0, `SCMC_IDX_DATA0, 32'h0, 4'hf);
        chk("rx0 data", {16'h0, 7'h02, 9'h03c}, r);
        apb(1'b1, `SCMC_IDX_IRQ_EN, 32'h0, 4'hf);
        @(posedge clk);
        chk("irq masked", 32'h0, 32'(irq));
        apb(1'b1, `SCMC_IDX_IRQ_CLR, 32'h1, 4'hf);
        apb(1'b1, `SCMC_IDX_IRQ_EN, 32'h3, 4'hf);
        @(posedge clk);
        chk("irq cleared", 32'h0, 32'(irq));
        apb(1'b1, `SCMC_IDX_MODE0, 32'h0020, 4'hf);
        apb(1'b0, `SCMC_IDX_MODE0, 32'h0, 4'hf);
        chk("mode0 while running", 32'h4020, r);
        apb(1'b1, `SCMC_IDX_CTRL, 32'h9, 4'hf);
        // channel 0: divided clock from tick a then tick b, divide by 2, completion event
        for (i = 0; i < 2; i++) begin
            apb(1'b1, `SCMC_IDX_MODE0, i[0] ? 32'h8020 : 32'h0020, 4'hf);
            apb(1'b1, `SCMC_IDX_DATA0, {16'h0, 7'h01, 9'h0c3}, 4'hf);
            apb(1'b1, `SCMC_IDX_CTRL, 32'h3, 4'hf);
            wait_irq;
            chk("div frame len", 32'h1, 32'(nk >= 30 + 30 * i && nk <= 36 + 32 * i));
            apb(1'b0, `SCMC_IDX_DATA0, 32'h0, 4'hf);
            chk("rx0 div data", {16'h0, 7'h01, 9'h0ff}, r);
            apb(1'b1, `SCMC_IDX_IRQ_CLR, 32'h1, 4'hf);
            apb(1'b1, `SCMC_IDX_CTRL, 32'h9, 4'hf);
        end
        // channel 1: uart receive, edge trigger, completion event, both polarities
        for (i = 0; i < 2; i++) begin
            b = 8'($random(seed));
            apb(1'b1, `SCMC_IDX_MODE1, i[0] ? 32'h4122 : 32'h4162, 4'hf);
            apb(1'b1, `SCMC_IDX_CTRL, 32'h5, 4'hf);
            apb(1'b0, `SCMC_IDX_STAT, 32'h0, 4'hf);
            chk("armed not busy", 32'h1, 32'({r[5], r[1]}));
            chk("irq before frame", 32'h0, 32'(irq));
            p1.frame(b, ~i[0], 1'b1, 3 + 3 * i, got);
            wait_irq;
            chk("irq on completion", 32'h1, 32'(irq));
            apb(1'b0, `SCMC_IDX_DATA1, 32'h0, 4'hf);
            chk("rx1 data", {24'h0, b}, r);
            apb(1'b1, `SCMC_IDX_IRQ_CLR, 32'h2, 4'hf);
            apb(1'b1, `SCMC_IDX_CTRL, 32'h11, 4'hf);
        end
        print_verdict;
    end
endmodule
